// file: pkg/counter_if.sv
// Carrier between the register bank and one saturating counter.
// Assumes both ends run on the same clock.
interface counter_if #(parameter int W = 8);
    logic         inc;
    logic         clr;
    logic [W-1:0] snap;
    logic [W-1:0] value;
    logic         half_evt;

    modport owner (output inc, output clr, output snap,
                   input value, input half_evt);
    modport counter (input inc, input clr, input snap,
                     output value, output half_evt);
endinterface : counter_if

// file: pkg/phy_event_pkg.sv
// Constants for the PHY event status and error counter register bank.
// Assumes an APB slave with 32-bit data; each register is one aligned word.
package phy_event_pkg;

    // ************************************************************
    // Bus geometry.
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_PHY_CTRL   = 6'h11;
    localparam logic [5:0] IDX_EVT_FIRST  = 6'h12;
    localparam logic [5:0] IDX_EVT_SECOND = 6'h13;
    localparam logic [5:0] IDX_FC_COUNT   = 6'h14;
    localparam logic [5:0] IDX_RE_COUNT   = 6'h15;

    // ************************************************************
    // Field layout.
    // ************************************************************
    localparam int EVT2_NUM      = 7;
    localparam int EVT2_STAT_LSB = 8;
    localparam int EVT2_EN_LSB   = 0;
    localparam int EVT1_NUM      = 2;
    localparam int EVT1_STAT_LSB = 8;
    localparam int EVT1_EN_LSB   = 0;
    localparam int CTRL_OE_BIT   = 0;
    localparam int CTRL_EN_BIT   = 1;

    // Event positions inside the second event register, above its LSB.
    localparam int EV_JABBER    = 0;
    localparam int EV_POLARITY  = 1;
    localparam int EV_SLEEP     = 2;
    localparam int EV_CROSSOVER = 3;
    localparam int EV_LOOP_FIFO = 4;
    localparam int EV_PAGE_RX   = 5;
    localparam int EV_AUTONEG   = 6;

    // Event positions inside the first event register, above its LSB.
    localparam int EV1_RE_HALF = 0;
    localparam int EV1_FC_HALF = 1;

    // ************************************************************
    // Reset values and counter limits.
    // ************************************************************
    localparam logic [EVT2_NUM-1:0] EVT2_RST = 7'h00;
    localparam logic [EVT1_NUM-1:0] EVT1_RST = 2'h0;
    localparam logic [1:0]          CTRL_RST = 2'h0;
    localparam int                  FC_W     = 8;
    localparam int                  RE_W     = 16;
    localparam logic [FC_W-1:0]     FC_HALF  = 8'h7f;
    localparam logic [FC_W-1:0]     FC_MAX   = 8'hff;
    localparam logic [RE_W-1:0]     RE_HALF  = 16'h7fff;
    localparam logic [RE_W-1:0]     RE_MAX   = 16'hffff;
    localparam logic [2:0]          SYNC_RST = 3'h7;

endpackage : phy_event_pkg

// file: rtl/phy_event_status_and_error_counters.sv
// Event status, enables and error counters of a 10/100 PHY, as an APB slave.
// Assumes event inputs are one-cycle pulses from logic on pclk.
//
// What this block does
// - Each second-register event latches and stays until that register is read.
// - A latched event interrupts only while its own enable bit is set.
// - Both global control bits must be set for any interrupt to leave.
// - Status bits latch even when the matching enable is clear.
// - Autoneg error at status bit 14, enable bit 6, reset zero.
// - Link partner page received at status bit 13, enable bit 5.
// - Loopback FIFO over or underflow at status bit 12, enable bit 4.
// - Straight or crossover wiring change at status bit 11, enable bit 3.
// - Sleep mode event at status bit 10, enable bit 2.
// - Received data polarity change at status bit 9, enable bit 1.
// - Jabber detect at status bit 8, enable bit 0.
// - Reserved bits ignore writes and read zero.
// - Eight-bit false carrier counter in bits 7:0 counts each event.
// - False carrier count passing 7Fh raises a half-full event.
// - Reading the false carrier register returns the count then clears it.
// - Sixteen-bit receive error counter counts symbol errors while data valid.
// - Receive error counter holds during MII loopback.
// - Receive error counter saturates at FFFFh and clears on read.
// - Receive error count passing 7FFFh raises a half-full event.
// - Half-full events latch in first register bits 9 and 8, enables 1 and 0.
// - Control bit 1 enables interrupts; bit 0 makes the pin an interrupt output.
module phy_event_status_and_error_counters (
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [phy_event_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [phy_event_pkg::DATA_W-1:0]   pwdata,
    output logic      [phy_event_pkg::DATA_W-1:0]   prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic                               autoneg_fault_evt,
    input  wire logic                               page_rx_evt,
    input  wire logic                               loop_fifo_fault_evt,
    input  wire logic                               crossover_change_evt,
    input  wire logic                               sleep_evt,
    input  wire logic                               polarity_change_evt,
    input  wire logic                               jabber_evt,
    input  wire logic                               false_carrier_evt,
    input  wire logic                               rx_dv,
    input  wire logic                               rx_symbol_err,
    input  wire logic                               mii_loopback,
    input  wire logic                               irq_or_powerdown_pin_in,
    output logic                                    irq_or_powerdown_pin_out,
    output logic                                    irq_or_powerdown_pin_oe,
    output logic                                    power_down_req
);

    // ************************************************************
    // Address decode.
    // ************************************************************

    // Index of a word address, or an all-ones code for a misaligned one.
    function automatic logic [5:0] reg_index(input logic [phy_event_pkg::ADDR_W-1:0] a);
        reg_index = (a[1:0] == 2'h0) ? a[7:2] : 6'h3f;
    endfunction : reg_index

    // True when the index names one of the five registers.
    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx == phy_event_pkg::IDX_PHY_CTRL)
                 || (idx == phy_event_pkg::IDX_EVT_FIRST)
                 || (idx == phy_event_pkg::IDX_EVT_SECOND)
                 || (idx == phy_event_pkg::IDX_FC_COUNT)
                 || (idx == phy_event_pkg::IDX_RE_COUNT);
    endfunction : is_mapped

    logic [5:0] idx;
    logic       setup_phase;
    logic       access_done;
    logic       wr_done;
    logic       rd_done;

    // A transfer ends at the edge where the access phase sees pready high.
    always_comb begin
        idx         = reg_index(paddr);
        setup_phase = psel && !penable;
        access_done = psel && penable && pready;
        wr_done     = access_done && pwrite && !pslverr;
        rd_done     = access_done && !pwrite && !pslverr;
    end

    // ************************************************************
    // State.
    // ************************************************************
    logic [phy_event_pkg::EVT2_NUM-1:0] evt2_stat_reg;
    logic [phy_event_pkg::EVT2_NUM-1:0] evt2_en_reg;
    logic [phy_event_pkg::EVT1_NUM-1:0] evt1_stat_reg;
    logic [phy_event_pkg::EVT1_NUM-1:0] evt1_en_reg;
    logic                               int_en_reg;
    logic                               int_oe_reg;
    logic [2:0]                         pin_sync_reg;
    logic                               pin_level_reg;

    logic [phy_event_pkg::EVT2_NUM-1:0] evt2_raw;
    logic [phy_event_pkg::EVT1_NUM-1:0] evt1_raw;
    logic [phy_event_pkg::EVT2_NUM-1:0] evt2_clr;
    logic [phy_event_pkg::EVT1_NUM-1:0] evt1_clr;
    logic [phy_event_pkg::REG_W-1:0]    rd_val;
    logic                               irq_active;

    counter_if #(.W(phy_event_pkg::FC_W)) fc_cnt ();
    counter_if #(.W(phy_event_pkg::RE_W)) re_cnt ();

    // ************************************************************
    // Counters.
    // ************************************************************

    // The snapshot is the value the bus already returned, so clearing never
    // discards a count taken between the setup and access cycles.
    always_comb begin
        fc_cnt.inc  = false_carrier_evt;
        fc_cnt.clr  = rd_done && (idx == phy_event_pkg::IDX_FC_COUNT);
        fc_cnt.snap = prdata[phy_event_pkg::FC_W-1:0];
        re_cnt.inc  = rx_dv && rx_symbol_err && !mii_loopback;
        re_cnt.clr  = rd_done && (idx == phy_event_pkg::IDX_RE_COUNT);
        re_cnt.snap = prdata[phy_event_pkg::RE_W-1:0];
    end

    // False carrier counter holding at its top value.
    sat_counter #(
        .W    (phy_event_pkg::FC_W),
        .HALF (phy_event_pkg::FC_HALF),
        .MAX  (phy_event_pkg::FC_MAX)
    ) u_fc_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .cnt     (fc_cnt.counter)
    );

    // Receive symbol error counter holding at its top value.
    sat_counter #(
        .W    (phy_event_pkg::RE_W),
        .HALF (phy_event_pkg::RE_HALF),
        .MAX  (phy_event_pkg::RE_MAX)
    ) u_re_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .cnt     (re_cnt.counter)
    );

    // ************************************************************
    // Event sources.
    // ************************************************************

    // Gather the second-register events in bit order above its LSB.
    always_comb begin
        evt2_raw = '0;
        evt2_raw[phy_event_pkg::EV_AUTONEG]   = autoneg_fault_evt;
        evt2_raw[phy_event_pkg::EV_PAGE_RX]   = page_rx_evt;
        evt2_raw[phy_event_pkg::EV_LOOP_FIFO] = loop_fifo_fault_evt;
        evt2_raw[phy_event_pkg::EV_CROSSOVER] = crossover_change_evt;
        evt2_raw[phy_event_pkg::EV_SLEEP]     = sleep_evt;
        evt2_raw[phy_event_pkg::EV_POLARITY]  = polarity_change_evt;
        evt2_raw[phy_event_pkg::EV_JABBER]    = jabber_evt;
        evt1_raw = '0;
        evt1_raw[phy_event_pkg::EV1_FC_HALF]  = fc_cnt.half_evt;
        evt1_raw[phy_event_pkg::EV1_RE_HALF]  = re_cnt.half_evt;
    end

    // Clear only the bits the ending read returned as set.
    always_comb begin
        evt2_clr = '0;
        evt1_clr = '0;
        if (rd_done && (idx == phy_event_pkg::IDX_EVT_SECOND)) begin
            evt2_clr = prdata[phy_event_pkg::EVT2_STAT_LSB +: phy_event_pkg::EVT2_NUM];
        end
        if (rd_done && (idx == phy_event_pkg::IDX_EVT_FIRST)) begin
            evt1_clr = prdata[phy_event_pkg::EVT1_STAT_LSB +: phy_event_pkg::EVT1_NUM];
        end
    end

    // ************************************************************
    // Status latches.
    // ************************************************************

    // Set wins over clear, and latching ignores the enables so polling works.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt2_stat_reg <= phy_event_pkg::EVT2_RST;
        end else begin
            evt2_stat_reg <= (evt2_stat_reg & ~evt2_clr) | evt2_raw;
        end
    end

    // Half-full latches of the first register behave the same way.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt1_stat_reg <= phy_event_pkg::EVT1_RST;
        end else begin
            evt1_stat_reg <= (evt1_stat_reg & ~evt1_clr) | evt1_raw;
        end
    end

    // ************************************************************
    // Writable fields.
    // ************************************************************

    // Enables of the second register; reserved bits 15 and 7 are dropped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt2_en_reg <= phy_event_pkg::EVT2_RST;
        end else if (wr_done && (idx == phy_event_pkg::IDX_EVT_SECOND)) begin
            evt2_en_reg <= pwdata[phy_event_pkg::EVT2_EN_LSB +: phy_event_pkg::EVT2_NUM];
        end
    end

    // Enables of the two half-full events.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt1_en_reg <= phy_event_pkg::EVT1_RST;
        end else if (wr_done && (idx == phy_event_pkg::IDX_EVT_FIRST)) begin
            evt1_en_reg <= pwdata[phy_event_pkg::EVT1_EN_LSB +: phy_event_pkg::EVT1_NUM];
        end
    end

    // Global interrupt enable and pin direction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en_reg <= phy_event_pkg::CTRL_RST[phy_event_pkg::CTRL_EN_BIT];
            int_oe_reg <= phy_event_pkg::CTRL_RST[phy_event_pkg::CTRL_OE_BIT];
        end else if (wr_done && (idx == phy_event_pkg::IDX_PHY_CTRL)) begin
            int_en_reg <= pwdata[phy_event_pkg::CTRL_EN_BIT];
            int_oe_reg <= pwdata[phy_event_pkg::CTRL_OE_BIT];
        end
    end

    // ************************************************************
    // Read path.
    // ************************************************************

    // Every unlisted bit reads zero; counters and status are read-only.
    always_comb begin
        rd_val = '0;
        unique case (idx)
            phy_event_pkg::IDX_PHY_CTRL: begin
                rd_val[phy_event_pkg::CTRL_EN_BIT] = int_en_reg;
                rd_val[phy_event_pkg::CTRL_OE_BIT] = int_oe_reg;
            end
            phy_event_pkg::IDX_EVT_FIRST: begin
                rd_val[phy_event_pkg::EVT1_STAT_LSB +: phy_event_pkg::EVT1_NUM] = evt1_stat_reg;
                rd_val[phy_event_pkg::EVT1_EN_LSB +: phy_event_pkg::EVT1_NUM]   = evt1_en_reg;
            end
            phy_event_pkg::IDX_EVT_SECOND: begin
                rd_val[phy_event_pkg::EVT2_STAT_LSB +: phy_event_pkg::EVT2_NUM] = evt2_stat_reg;
                rd_val[phy_event_pkg::EVT2_EN_LSB +: phy_event_pkg::EVT2_NUM]   = evt2_en_reg;
            end
            phy_event_pkg::IDX_FC_COUNT: begin
                rd_val[phy_event_pkg::FC_W-1:0] = fc_cnt.value;
            end
            phy_event_pkg::IDX_RE_COUNT: begin
                rd_val = re_cnt.value;
            end
            default: begin
                rd_val = '0;
            end
        endcase
    end

    // The word is captured in the setup cycle so that prdata is a flop; the
    // price is that the read shows state one cycle before the access edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_phase) begin
            prdata <= pwrite ? '0 : {{(phy_event_pkg::DATA_W - phy_event_pkg::REG_W){1'b0}}, rd_val};
        end
    end

    // One wait-free access phase; unmapped or misaligned addresses error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase && !is_mapped(idx);
        end
    end

    // ************************************************************
    // Interrupt and power-down pin.
    // ************************************************************

    // Level interrupt: it stays while any enabled bit pends.
    always_comb begin
        irq_active = ((|(evt2_stat_reg & evt2_en_reg))
                   || (|(evt1_stat_reg & evt1_en_reg)))
                   && int_en_reg && int_oe_reg;
    end

    // Active-low output, driven only while the pin is set as an output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_or_powerdown_pin_out <= 1'b1;
            irq_or_powerdown_pin_oe  <= 1'b0;
        end else begin
            irq_or_powerdown_pin_out <= !irq_active;
            irq_or_powerdown_pin_oe  <= int_oe_reg;
        end
    end

    // Three-stage synchroniser on the pin; the first stage feeds only the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_reg <= phy_event_pkg::SYNC_RST;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], irq_or_powerdown_pin_in};
        end
    end

    // A new level counts once the last two stages agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level_reg <= 1'b1;
        end else if (pin_sync_reg[1] == pin_sync_reg[2]) begin
            pin_level_reg <= pin_sync_reg[2];
        end
    end

    // A low pin requests power-down only while the pin is an input.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down_req <= 1'b0;
        end else begin
            power_down_req <= !pin_level_reg && !int_oe_reg;
        end
    end

endmodule : phy_event_status_and_error_counters

// file: rtl/sat_counter.sv
// Saturating clear-on-read event counter with a half-full crossing pulse.
// Assumes snap holds the value that the bus returned for the read now ending.
module sat_counter #(
    parameter int           W    = 8,
    parameter logic [W-1:0] HALF = '0,
    parameter logic [W-1:0] MAX  = '1
) (
    input wire logic pclk,
    input wire logic presetn,
    counter_if.counter cnt
);

    logic [W-1:0] count_reg;
    logic [W-1:0] base;
    logic         step;

    // ************************************************************
    // Next value.
    // ************************************************************
    // Only the returned amount is removed, so a count in the same cycle survives.
    always_comb begin
        base = cnt.clr ? W'(count_reg - cnt.snap) : count_reg;
        step = cnt.inc && (base != MAX);
    end

    // Holding at the top keeps a full counter from reading as nearly empty.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= W'(base + W'(step));
        end
    end

    assign cnt.value    = count_reg;
    assign cnt.half_evt = step && (base == HALF); // Crossing above half.

endmodule : sat_counter

// file: tb/apb_mgmt_model.sv
// Station management master model that issues single APB reads and writes.
// Assumes one clock shared with the register bank; the bench calls xfer.
module apb_mgmt_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Bus transfers.
    // ****************************************
    // Idle bus at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Setup, then access held until pready is seen at an edge.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_mgmt_model

// file: tb/phy_event_properties.sv
// Concurrent checks on the ports of the PHY event register bank.
// Assumes a bind to the top module; one clock, asynchronous low reset.
module phy_event_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq_or_powerdown_pin_out,
    input wire logic        irq_or_powerdown_pin_oe,
    input wire logic        power_down_req
);
    // ****************************************
    // Bus phases and port relations.
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Phases of a transfer as the master presents them.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_bad_read;
        s_setup ##0 (!pwrite && (paddr[1:0] != 2'h0 || paddr[7:2] < 6'h11 || paddr[7:2] > 6'h15));
    endsequence
    sequence s_rd_access(a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    a_ready_follows: assert property (s_setup |=> pready) else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
    a_error_unmapped: assert property (s_bad_read |=> pslverr && prdata == 32'h0)
        else $error("bad address not refused");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    a_evt2_reserved: assert property (s_rd_access(8'h4c) |-> !prdata[15] && !prdata[7])
        else $error("reserved event bit set");
    a_fc_upper: assert property (s_rd_access(8'h50) |-> prdata[15:8] == 8'h00)
        else $error("counter upper byte set");
    a_oe_write: assert property (psel && penable && pready && pwrite && paddr == 8'h44
        |-> ##2 irq_or_powerdown_pin_oe == $past(pwdata[0], 2)) else $error("pin enable wrong");
    a_irq_gated: assert property (!irq_or_powerdown_pin_out |-> irq_or_powerdown_pin_oe)
        else $error("interrupt while pin is input");
    a_pd_input: assert property (power_down_req |-> !irq_or_powerdown_pin_oe)
        else $error("power down while pin is output");
endmodule : phy_event_properties

bind phy_event_status_and_error_counters phy_event_properties chk_u (.*);

// file: tb/phy_event_status_and_error_counters_tb.sv
// Self-checking bench for the PHY event register bank.
// Assumes the management model drives APB and the bench drives all event inputs.
module phy_event_status_and_error_counters_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, e;
    logic        psel, penable, pwrite, pready, pslverr, pin_out, pin_oe, pd_req;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [6:0]  ev = 7'h00;
    logic        fc = 1'b0, dv = 1'b0, rxe = 1'b0, lb = 1'b0, pin_drv = 1'b1;
    int          fail_count = 0, compares = 0;
    // The shared pin follows the block while it drives, else the bench.
    wire logic   pin_lvl = pin_oe ? pin_out : pin_drv;
    // ****************************************
    // Clock, instances and helpers.
    // ****************************************
    always #2.5 pclk = ~pclk;
    apb_mgmt_model mgmt_u (.*);
    phy_event_status_and_error_counters dut_u (.*,
        .autoneg_fault_evt(ev[6]), .page_rx_evt(ev[5]), .loop_fifo_fault_evt(ev[4]),
        .crossover_change_evt(ev[3]), .sleep_evt(ev[2]), .polarity_change_evt(ev[1]),
        .jabber_evt(ev[0]), .false_carrier_evt(fc), .rx_dv(dv), .rx_symbol_err(rxe),
        .mii_loopback(lb), .irq_or_powerdown_pin_in(pin_lvl), .irq_or_powerdown_pin_out(pin_out),
        .irq_or_powerdown_pin_oe(pin_oe), .power_down_req(pd_req));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Pin levels are looked at once the edge's updates have landed.
    task chkb(input logic got, input logic exp);
        #1 chk({31'h0, got}, {31'h0, exp});
    endtask : chkb
    task rd(input logic [7:0] a); mgmt_u.xfer(1'b0, a, 32'h0, q, e); endtask : rd
    task wr(input logic [7:0] a, input logic [31:0] d); mgmt_u.xfer(1'b1, a, d, q, e); endtask : wr
    task hold(input int n); repeat (n) @(posedge pclk); endtask : hold
    task pulse(input int i);
        @(posedge pclk) ev[i] <= 1'b1;
        @(posedge pclk) ev[i] <= 1'b0;
    endtask : pulse
    // A level held n cycles counts n times.
    task fc_burst(input int n);
        @(posedge pclk) fc <= 1'b1;
        hold(n);
        fc <= 1'b0;
    endtask : fc_burst
    task re_burst(input int n, input logic v, input logic l);
        @(posedge pclk) {dv, rxe, lb} <= {v, 1'b1, l};
        hold(n);
        {dv, rxe, lb} <= 3'h0;
    endtask : re_burst
    // ****************************************
    // Scenarios.
    // ****************************************
    task t_reset;
        for (int i = 0; i < 5; i++) begin
            rd(8'h44 + 8'(4 * i));
            chk(q, 32'h0);
        end
        rd(8'h58);
        chkb(e, 1'b1);
        rd(8'h4e);
        chkb(e, 1'b1);
    endtask : t_reset
    task t_events;
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            rd(8'h4c);
            chk(q, 32'h1 << (phy_event_pkg::EVT2_STAT_LSB + i));
            rd(8'h4c);
            chk(q, 32'h0);
        end
    endtask : t_events
    task t_irq;
        wr(8'h4c, 32'hffffffff);
        rd(8'h4c);
        chk(q, 32'h7f);
        wr(8'h4c, 32'h40);
        wr(8'h44, 32'h3);
        pulse(5);
        hold(3);
        chkb(pin_out, 1'b1);
        pulse(6);
        hold(2);
        chkb(pin_out, 1'b0);
        wr(8'h44, 32'h2);
        hold(2);
        chkb(pin_out, 1'b1);
        wr(8'h44, 32'h3);
        hold(2);
        chkb(pin_out, 1'b0);
        rd(8'h4c);
        chk(q, 32'h6040);
        hold(2);
        chkb(pin_out, 1'b1);
        wr(8'h44, 32'h0);
        wr(8'h4c, 32'h0);
    endtask : t_irq
    task t_counters;
        fc_burst(127);
        rd(8'h48);
        chk(q, 32'h0);
        rd(8'h50);
        chk(q, 32'h7f);
        fc_burst(300);
        rd(8'h50);
        chk(q, 32'hff);
        rd(8'h48);
        chk(q, 32'h200);
        re_burst(10, 1'b1, 1'b0);
        re_burst(6, 1'b1, 1'b1);
        re_burst(5, 1'b0, 1'b0);
        rd(8'h54);
        chk(q, 32'ha);
        re_burst(32767, 1'b1, 1'b0);
        rd(8'h48);
        chk(q, 32'h0);
        re_burst(1, 1'b1, 1'b0);
        rd(8'h48);
        chk(q, 32'h100);
        re_burst(32768, 1'b1, 1'b0);
        rd(8'h54);
        chk(q, 32'hffff);
        rd(8'h54);
        chk(q, 32'h0);
    endtask : t_counters
    // Events land on the clearing edge of a read and must survive it.
    task t_race;
        fork
            rd(8'h4c);
            begin hold(1); pulse(0); end
        join
        rd(8'h4c);
        chk(q, 32'h100);
        fork
            rd(8'h50);
            begin hold(1); fc_burst(1); end
        join
        rd(8'h50);
        chk(q, 32'h1);
    endtask : t_race
    task t_pd;
        @(posedge pclk) pin_drv <= 1'b0;
        hold(8);
        chkb(pd_req, 1'b1);
        @(posedge pclk) pin_drv <= 1'b1;
        hold(8);
        chkb(pd_req, 1'b0);
    endtask : t_pd
    task summarize;
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    // Main sequence after 20 cycles of reset.
    initial begin
        hold(20);
        presetn <= 1'b1;
        t_reset();
        t_events();
        t_irq();
        t_counters();
        t_race();
        t_pd();
        summarize();
    end
    // The tests take about 66000 cycles; the watchdog allows 90000.
    initial begin
        #450000;
        fail_count++;
        summarize();
    end
endmodule : phy_event_status_and_error_counters_tb
